/* uoe_pkg.sv */
// Constants and types for the output endpoint descriptor block
package uoe_pkg;
  // Descriptor window in the microcontroller data space
  localparam logic [15:0] EDB_BASE_ADDR   = 16'hFF08;
  localparam logic [15:0] EDB_LAST_ADDR   = 16'hFF1F;
  localparam int          EP_COUNT        = 3;
  // Entry offsets inside one eight-byte descriptor
  localparam logic [2:0]  OFS_CONFIG      = 3'h0;
  localparam logic [2:0]  OFS_X_BASE      = 3'h1;
  localparam logic [2:0]  OFS_X_COUNT     = 3'h2;
  localparam logic [2:0]  OFS_Y_BASE      = 3'h5;
  localparam logic [2:0]  OFS_Y_COUNT     = 3'h6;
  localparam logic [2:0]  OFS_XY_SIZE     = 3'h7;
  // Bit positions in out_endpoint_config
  localparam int          CFG_ENABLE      = 7;
  localparam int          CFG_PERIODIC    = 6;
  localparam int          CFG_TOGGLE      = 5;
  localparam int          CFG_DOUBLE_BUF  = 4;
  localparam int          CFG_HALT        = 3;
  localparam int          CFG_IRQ_EN      = 2;
  localparam logic [7:0]  CFG_WRITE_MASK  = 8'hFC;
  // Bit positions in the count entries
  localparam int          CNT_OWNED       = 7;
  localparam logic [6:0]  MAX_PACKET      = 7'h40;
  localparam logic [7:0]  SIZE_WRITE_MASK = 8'h7F;
  // Reset value of every descriptor byte
  localparam logic [7:0]  EDB_RESET       = 8'h00;
  // Handshake codes returned to the serial engine
  localparam logic [1:0]  HS_NONE         = 2'h0;
  localparam logic [1:0]  HS_ACK          = 2'h1;
  localparam logic [1:0]  HS_NAK          = 2'h2;
  localparam logic [1:0]  HS_STALL        = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_DROP,
    ST_FLUSH
  } uoe_state_t;
endpackage

/* uoe_out_endpoint.sv */
// Output endpoint descriptors and OUT packet buffer manager for endpoints 1 to 3
`timescale 1ns/1ns
// Functional notes
// R1 - Completion pulse per endpoint is raised only when its interrupt enable is set.
// R2 - Halt bit resets low, forces STALL replies; only software clears it.
// R3 - Without double buffering use X only; with it, the sequence bit picks.
// R4 - Data sequence bit tracks the DATA0/DATA1 toggle of each endpoint.
// R5 - Software keeps the periodic select bit cleared; it has no effect.
// R6 - An endpoint with its enable bit clear is never serviced.
// R7 - Base entries hold address bits 10:3; three zero bits are appended.
// R8 - Software programs both base entries before enabling the endpoint.
// R9 - Packet data is written starting at the selected buffer's base address.
// R10 - Base entries are never modified by the buffer manager.
// R11 - Count field holds packet length in bytes, zero to 64.
// R12 - Software never writes a count of 65 or more.
// R13 - Ownership flag clear: buffer empty, next OUT packet is accepted.
// R14 - Ownership flag set: further OUT packets to that buffer get NAK.
// R15 - Eight-byte descriptor: config 0, X base 1, X count 2, Y 5, 6, size 7.
// R16 - On acceptance write length, set ownership flag and flip the sequence bit.
// R17 - Software clears the ownership flag after consuming the packet.
// R18 - With double buffering, sequence bit set selects the Y entries.
module uoe_out_endpoint
  import uoe_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Microcontroller data-space access to the descriptors
  input  wire logic [15:0] mcu_addr,
  input  wire logic        mcu_wr,
  input  wire logic [7:0]  mcu_wdata,
  input  wire logic        mcu_rd,
  output logic      [7:0]  mcu_rdata,
  // OUT token and packet data from the serial engine
  input  wire logic        sie_token_valid,
  input  wire logic [3:0]  sie_token_ep,
  input  wire logic        sie_byte_valid,
  input  wire logic [7:0]  sie_byte,
  output logic             sie_byte_ready,
  input  wire logic        sie_packet_end,
  // Handshake back to the serial engine
  output logic             sie_hs_valid,
  output logic      [1:0]  sie_hs_code,
  // Buffer RAM write port
  output logic             ram_wr_valid,
  output logic      [10:0] ram_wr_addr,
  output logic      [7:0]  ram_wr_data,
  input  wire logic        ram_wr_ready,
  // Transaction completion pulses, one per endpoint
  output logic      [2:0]  ep_done_irq
);

  typedef struct packed {
    logic [2:0][7:0] cfg;
    logic [2:0][7:0] x_base;
    logic [2:0][7:0] x_count;
    logic [2:0][7:0] y_base;
    logic [2:0][7:0] y_count;
    logic [2:0][7:0] xy_size;
    logic [7:0]      rdata;
    uoe_state_t      state;
    logic [1:0]      ep;
    logic            sel_y;
    logic [10:0]     start;
    logic [6:0]      len;
    logic [1:0]      pend_code;
    logic            hs_valid;
    logic [1:0]      hs_code;
    logic            in_ready;
    logic            head_v;
    logic [10:0]     head_addr;
    logic [7:0]      head_data;
    logic            spare_v;
    logic [10:0]     spare_addr;
    logic [7:0]      spare_data;
    logic [2:0]      irq;
  } uoe_regs_t;

  uoe_regs_t q;
  uoe_regs_t d;

  logic [4:0]  rel;
  logic [1:0]  idx;
  logic [2:0]  ofs;
  logic        hit;
  logic        tok_ok;
  logic [1:0]  tok_idx;
  logic        tok_y;
  logic        tok_own;
  logic        in_fire;
  logic        push;
  logic [10:0] push_addr;

  // Descriptor address decode
  assign rel = 5'(mcu_addr - EDB_BASE_ADDR);
  assign idx = rel[4:3];
  assign ofs = rel[2:0];
  assign hit = (mcu_addr >= EDB_BASE_ADDR) && (mcu_addr <= EDB_LAST_ADDR);

  // Token endpoint lookup and buffer selection
  assign tok_ok  = (sie_token_ep >= 4'h1) && (sie_token_ep <= 4'h3);
  assign tok_idx = 2'(sie_token_ep - 4'h1);
  // Gated by tok_ok so an unserviced endpoint number never selects the Y entries; tok_own and the enable check still index with tok_idx
  assign tok_y   = tok_ok && q.cfg[tok_idx][CFG_DOUBLE_BUF] && q.cfg[tok_idx][CFG_TOGGLE]; // [R3] [R18]
  assign tok_own = tok_y ? q.y_count[tok_idx][CNT_OWNED] : q.x_count[tok_idx][CNT_OWNED];

  // Data byte accepted and forwarded to the RAM buffer
  assign in_fire   = sie_byte_valid && q.in_ready;
  assign push      = in_fire && (q.state == ST_RECV) && (q.len < MAX_PACKET); // [R11]
  assign push_addr = q.start + 11'(q.len); // [R9]

  // Next-state logic for descriptors, sequencer and buffer
  always_comb begin
    d          = q;
    d.hs_valid = 1'b0;
    d.irq      = 3'b000;
    d.rdata    = 8'h00;

    // Software writes; base entries change only here [R10]
    if (mcu_wr && hit) begin
      if (ofs == OFS_CONFIG) begin
        d.cfg[idx] = mcu_wdata & CFG_WRITE_MASK; // [R2] [R15]
      end else if (ofs == OFS_X_BASE) begin
        d.x_base[idx] = mcu_wdata;
      end else if (ofs == OFS_X_COUNT) begin
        d.x_count[idx] = mcu_wdata; // [R17]
      end else if (ofs == OFS_Y_BASE) begin
        d.y_base[idx] = mcu_wdata;
      end else if (ofs == OFS_Y_COUNT) begin
        d.y_count[idx] = mcu_wdata;
      end else if (ofs == OFS_XY_SIZE) begin
        d.xy_size[idx] = mcu_wdata & SIZE_WRITE_MASK;
      end
    end

    // Software reads, registered; spare offsets and misses read zero
    if (mcu_rd && hit) begin
      if (ofs == OFS_CONFIG) begin
        d.rdata = q.cfg[idx];
      end else if (ofs == OFS_X_BASE) begin
        d.rdata = q.x_base[idx];
      end else if (ofs == OFS_X_COUNT) begin
        d.rdata = q.x_count[idx];
      end else if (ofs == OFS_Y_BASE) begin
        d.rdata = q.y_base[idx];
      end else if (ofs == OFS_Y_COUNT) begin
        d.rdata = q.y_count[idx];
      end else if (ofs == OFS_XY_SIZE) begin
        d.rdata = q.xy_size[idx];
      end
    end

    // Two-entry buffer: head drains to RAM, spare catches a stalled word
    if (q.head_v && ram_wr_ready) begin
      d.head_v = 1'b0;
    end
    if (d.spare_v && !d.head_v) begin
      d.head_v    = 1'b1;
      d.head_addr = d.spare_addr;
      d.head_data = d.spare_data;
      d.spare_v   = 1'b0;
    end
    if (push) begin
      if (!d.head_v) begin
        d.head_v    = 1'b1;
        d.head_addr = push_addr;
        d.head_data = sie_byte;
      end else begin
        d.spare_v    = 1'b1;
        d.spare_addr = push_addr;
        d.spare_data = sie_byte;
      end
      d.len = q.len + 7'h01;
    end

    // OUT transaction sequencer
    case (q.state)
      ST_IDLE: begin
        if (sie_token_valid) begin
          d.ep    = tok_idx;
          d.sel_y = tok_y;
          d.len   = 7'h00;
          d.state = ST_DROP;
          if (!tok_ok || !q.cfg[tok_idx][CFG_ENABLE]) begin
            d.pend_code = HS_NONE; // [R6]
          end else if (q.cfg[tok_idx][CFG_HALT]) begin
            d.pend_code = HS_STALL; // [R2]
          end else if (tok_own) begin
            d.pend_code = HS_NAK; // [R14]
          end else begin
            d.state = ST_RECV; // [R13]
            d.start = tok_y ? {q.y_base[tok_idx], 3'b000}
                            : {q.x_base[tok_idx], 3'b000}; // [R7] [R9]
          end
        end
      end
      ST_RECV: begin
        if (sie_packet_end) begin
          d.state = ST_FLUSH;
        end
      end
      ST_DROP: begin
        if (sie_packet_end) begin
          d.state    = ST_IDLE;
          d.hs_valid = (q.pend_code != HS_NONE);
          d.hs_code  = q.pend_code;
        end
      end
      ST_FLUSH: begin
        if (!q.head_v && !q.spare_v) begin
          // Commit after every byte has reached RAM; hardware set wins over software clear
          if (q.sel_y) begin
            d.y_count[q.ep] = {1'b1, q.len}; // [R11] [R16] [R18]
          end else begin
            d.x_count[q.ep] = {1'b1, q.len}; // [R16] [R3]
          end
          d.cfg[q.ep][CFG_TOGGLE] = ~q.cfg[q.ep][CFG_TOGGLE]; // [R4] [R16]
          d.irq[q.ep]  = q.cfg[q.ep][CFG_IRQ_EN]; // [R1]
          d.hs_valid   = 1'b1;
          d.hs_code    = HS_ACK;
          d.state      = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Registered ready: drop mode swallows bytes, receive stalls when spare is busy
    d.in_ready = (d.state == ST_DROP) || ((d.state == ST_RECV) && !d.spare_v);
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q.cfg        <= {EP_COUNT{EDB_RESET}}; // [R2]
      q.x_base     <= {EP_COUNT{EDB_RESET}};
      q.x_count    <= {EP_COUNT{EDB_RESET}};
      q.y_base     <= {EP_COUNT{EDB_RESET}};
      q.y_count    <= {EP_COUNT{EDB_RESET}};
      q.xy_size    <= {EP_COUNT{EDB_RESET}};
      q.rdata      <= 8'h00;
      q.state      <= ST_IDLE;
      q.ep         <= 2'b00;
      q.sel_y      <= 1'b0;
      q.start      <= 11'h000;
      q.len        <= 7'h00;
      q.pend_code  <= HS_NONE;
      q.hs_valid   <= 1'b0;
      q.hs_code    <= HS_NONE;
      q.in_ready   <= 1'b0;
      q.head_v     <= 1'b0;
      q.head_addr  <= 11'h000;
      q.head_data  <= 8'h00;
      q.spare_v    <= 1'b0;
      q.spare_addr <= 11'h000;
      q.spare_data <= 8'h00;
      q.irq        <= 3'b000;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign mcu_rdata      = q.rdata;
  assign sie_byte_ready = q.in_ready;
  assign sie_hs_valid   = q.hs_valid;
  assign sie_hs_code    = q.hs_code;
  assign ram_wr_valid   = q.head_v;
  assign ram_wr_addr    = q.head_addr;
  assign ram_wr_data    = q.head_data;
  assign ep_done_irq    = q.irq;

endmodule

/* uoe_chk_assertions.sv */
// Port checks on the output endpoint descriptor block
`timescale 1ns/1ns
module uoe_chk
  import uoe_pkg::*;
(
  // Clock, reset, register port
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [15:0] mcu_addr,
  input wire logic        mcu_rd,
  input wire logic [7:0]  mcu_rdata,
  // Handshake, RAM, completion
  input wire logic        sie_hs_valid,
  input wire logic [1:0]  sie_hs_code,
  input wire logic        ram_wr_valid,
  input wire logic [10:0] ram_wr_addr,
  input wire logic [7:0]  ram_wr_data,
  input wire logic        ram_wr_ready,
  input wire logic [2:0]  ep_done_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic hole;
  // Addresses that always read as zero
  assign hole = mcu_addr < EDB_BASE_ADDR || mcu_addr > EDB_LAST_ADDR ||
                mcu_addr[2:0] == 3'h3 || mcu_addr[2:0] == 3'h4;
  irq_with_ack_a: assert property (|ep_done_irq |-> sie_hs_valid && sie_hs_code == HS_ACK)
    else $error("completion pulse without ACK");
  irq_single_a: assert property ($onehot0(ep_done_irq))
    else $error("several completion pulses at once");
  hs_pulse_a: assert property (sie_hs_valid |=> !sie_hs_valid)
    else $error("handshake longer than one cycle");
  hs_code_a: assert property (sie_hs_valid |-> sie_hs_code != HS_NONE)
    else $error("handshake without code");
  ram_hold_a: assert property (ram_wr_valid && !ram_wr_ready |=>
    ram_wr_valid && $stable(ram_wr_addr) && $stable(ram_wr_data))
    else $error("RAM write changed while stalled");
  rd_idle_a: assert property (!mcu_rd |=> mcu_rdata == 8'h00)
    else $error("read data without read");
  rd_hole_a: assert property (mcu_rd && hole |=> mcu_rdata == 8'h00)
    else $error("unused address read nonzero");
  cfg_low_a: assert property (mcu_rd && mcu_addr[2:0] == OFS_CONFIG |=> !mcu_rdata[1]
    && !mcu_rdata[0])
    else $error("config low bits nonzero");
endmodule
bind uoe_out_endpoint uoe_chk u_chk (.core_clk, .resetn, .mcu_addr, .mcu_rd, .mcu_rdata,
  .sie_hs_valid, .sie_hs_code, .ram_wr_valid, .ram_wr_addr, .ram_wr_data, .ram_wr_ready,
  .ep_done_irq);

/* uoe_host_model.sv */
// Behavioural USB host sending OUT transactions
`timescale 1ns/1ns
module uoe_host_model
  import uoe_pkg::*;
(
  // Clock and replies from the block
  input  wire logic       core_clk,
  input  wire logic       sie_byte_ready,
  input  wire logic       sie_hs_valid,
  input  wire logic [1:0] sie_hs_code,
  // Token, data, end of packet
  output logic            sie_token_valid,
  output logic      [3:0] sie_token_ep,
  output logic            sie_byte_valid,
  output logic      [7:0] sie_byte,
  output logic            sie_packet_end
);
  // Idle bus at time zero
  initial begin
    sie_token_valid = 1'b0;
    sie_token_ep    = 4'h0;
    sie_byte_valid  = 1'b0;
    sie_byte        = 8'h00;
    sie_packet_end  = 1'b0;
  end
  // One transaction; hs stays NONE when the block is silent
  task automatic send(input logic [3:0] ep, input int n, input logic [7:0] b0,
                      output logic [1:0] hs);
    int k;
    @(negedge core_clk);
    sie_token_valid = 1'b1;
    sie_token_ep    = ep;
    @(negedge core_clk);
    sie_token_valid = 1'b0;
    for (int i = 0; i < n; i++) begin
      sie_byte_valid = 1'b1;
      sie_byte       = b0 + 8'(i);
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (!sie_byte_ready && k < 60);
      @(negedge core_clk);
    end
    // Released data line shows the inverse, not the last byte
    sie_byte_valid = 1'b0;
    sie_byte       = ~sie_byte;
    sie_packet_end = 1'b1;
    @(negedge core_clk);
    sie_packet_end = 1'b0;
    hs = HS_NONE;
    for (k = 0; k < 80 && hs === HS_NONE; k++) begin
      @(posedge core_clk);
      if (sie_hs_valid) hs = sie_hs_code;
    end
    @(negedge core_clk);
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the output endpoint descriptor block
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb
  import uoe_pkg::*;
;
  logic        core_clk = 1'b0, resetn = 1'b0, mcu_wr = 1'b0, mcu_rd = 1'b0;
  logic        ram_wr_ready = 1'b1, stall = 1'b0;
  logic [15:0] mcu_addr = 16'h0000;
  logic [7:0]  mcu_wdata = 8'h00, mcu_rdata, sie_byte, ram_wr_data, ld;
  logic        sie_token_valid, sie_byte_valid, sie_byte_ready, sie_packet_end;
  logic        sie_hs_valid, ram_wr_valid;
  logic [3:0]  sie_token_ep;
  logic [1:0]  sie_hs_code, hs;
  logic [10:0] ram_wr_addr, a0;
  logic [2:0]  ep_done_irq, irq_seen;
  logic [7:0]  msk [8] = '{CFG_WRITE_MASK, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF,
                           SIZE_WRITE_MASK};
  int          nw = 0, nw0 = 0, n_mismatch = 0, n_compared = 0;
  initial forever #5 core_clk = ~core_clk;
  uoe_out_endpoint u_dut (.core_clk, .resetn, .mcu_addr, .mcu_wr, .mcu_wdata, .mcu_rd,
    .mcu_rdata, .sie_token_valid, .sie_token_ep, .sie_byte_valid, .sie_byte,
    .sie_byte_ready, .sie_packet_end, .sie_hs_valid, .sie_hs_code, .ram_wr_valid,
    .ram_wr_addr, .ram_wr_data, .ram_wr_ready, .ep_done_irq);
  uoe_host_model u_host (.core_clk, .sie_byte_ready, .sie_hs_valid, .sie_hs_code,
    .sie_token_valid, .sie_token_ep, .sie_byte_valid, .sie_byte, .sie_packet_end);
  // RAM side stalls every other cycle on demand and logs what lands
  always @(negedge core_clk) ram_wr_ready <= stall ? ~ram_wr_ready : 1'b1;
  always @(posedge core_clk) begin
    if (sie_hs_valid) irq_seen <= ep_done_irq;
    if (ram_wr_valid && ram_wr_ready) begin
      if (nw == nw0) a0 <= ram_wr_addr;
      nw <= nw + 1;
      ld <= ram_wr_data;
    end
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    mcu_addr  = a;
    mcu_wdata = d;
    mcu_wr    = 1'b1;
    @(negedge core_clk);
    mcu_wr    = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge core_clk);
    mcu_addr = a;
    mcu_rd   = 1'b1;
    @(negedge core_clk);
    mcu_rd   = 1'b0;
    `CHK("mcu_rdata", e, mcu_rdata)
  endtask
  task automatic xfer(input logic [3:0] ep, input int n, input logic [7:0] b0,
                      input logic [1:0] e);
    // Snapshot of the write log; only the logging process drives nw and irq_seen
    nw0 = nw;
    u_host.send(ep, n, b0, hs);
    `CHK("sie_hs_code", e, hs)
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Tests take about a thousand cycles; the watchdog allows twenty thousand
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    for (int a = 0; a < 24; a++) rd(EDB_BASE_ADDR + 16'(a), EDB_RESET);
    for (int o = 7; o >= 0; o--) wr(16'hFF08 + 16'(o), 8'hBC);
    for (int o = 0; o < 8; o++) rd(16'hFF08 + 16'(o), 8'hBC & msk[o]);
    wr(16'hFF20, 8'hBC);
    rd(16'hFF20, 8'h00);
    for (int o = 0; o < 8; o++) wr(16'hFF08 + 16'(o), 8'h00);
    $display("test registers done");
    wr(16'hFF09, 8'h10);
    wr(16'hFF08, 8'h84);
    xfer(4'h1, 5, 8'h30, HS_ACK);
    `CHK("irq", 3'b001, irq_seen)
    `CHK("addr", {8'h10, 3'b000}, a0)
    `CHK("data", 8'h34, ld)
    rd(16'hFF0A, 8'h85);
    rd(16'hFF08, 8'hA4);
    rd(16'hFF09, 8'h10);
    xfer(4'h1, 2, 8'h50, HS_NAK);
    `CHK("bytes", 0, nw - nw0)
    wr(16'hFF0A, 8'h00);
    xfer(4'h1, 1, 8'h60, HS_ACK);
    `CHK("addr", {8'h10, 3'b000}, a0)
    `CHK("bytes", 1, nw - nw0)
    `CHK("data", 8'h60, ld)
    $display("test single buffer done");
    wr(16'hFF0A, 8'h00);
    wr(16'hFF08, 8'h8C);
    xfer(4'h1, 1, 8'h70, HS_STALL);
    rd(16'hFF08, 8'h8C);
    wr(16'hFF08, 8'h84);
    xfer(4'h1, 1, 8'h71, HS_ACK);
    $display("test halt done");
    wr(16'hFF11, 8'h20);
    wr(16'hFF15, 8'h30);
    wr(16'hFF10, 8'hB0);
    stall = 1'b1;
    xfer(4'h2, 70, 8'h00, HS_ACK);
    `CHK("addr", {8'h30, 3'b000}, a0)
    `CHK("bytes", 64, nw - nw0)
    `CHK("irq", 3'b000, irq_seen)
    rd(16'hFF16, 8'hC0);
    xfer(4'h2, 3, 8'h40, HS_ACK);
    `CHK("addr", {8'h20, 3'b000}, a0)
    rd(16'hFF12, 8'h83);
    stall = 1'b0;
    $display("test double buffer done");
    for (int e = 0; e < 16; e += 3) begin
      xfer(4'(e), 2, 8'h11, HS_NONE);
      `CHK("bytes", 0, nw - nw0)
    end
    $display("test disabled done");
    stop_test();
  end
endmodule
